// File: flag_group.sv
/*
  Merges the flags of one source group into a single request and a
  vector code: twice the index plus two of the lowest enabled flag.
  Assumes flags come from logic on the same clock.
*/
`timescale 1ns/1ps
module flag_group #(
  parameter int N = 4,      // Flags in the group
  parameter int CW = 5      // Width of the code
) (
  input wire logic [N-1:0] flags,   // Raw flags
  input wire logic [N-1:0] enables, // Flags that count in this mode
  output logic any,                 // Some enabled flag set
  output logic [CW-1:0] code        // 0 when none, else 2*(i+1)
);

  // ----------------------------------------------------------------
  // Lowest index wins, as in a vector register
  // ----------------------------------------------------------------
  always_comb begin
    any = 1'b0;
    code = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (flags[i] && enables[i]) begin
        any = 1'b1;
        code = CW'((i + 1) * 2);
      end
    end
  end

endmodule

// File: interrupt_vector_priority.sv
/*
  Interrupt vector and priority logic with its AXI4-Lite register file.
  Gathers grouped source flags, picks the highest pending source and
  presents its vector word address and handler word to the core.
  Assumes all flags are synchronous to aclk and that the bus master keeps
  AXI4-Lite rules (one write and one read under way at a time).
*/
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module interrupt_vector_priority #(
  parameter int ADDR_W = 18          // Byte address width of the bus
) (
  input wire logic aclk,                 // System clock, 20 MHz
  input wire logic aresetn,              // Synchronous reset, active low
  // Flag inputs
  input wire logic [8:0] reset_flags,    // Reset causes
  input wire logic [4:0] sys_nmi_flags,  // Vacant, mbox in/out, time, bit err
  input wire logic [1:0] user_nmi_flags, // Pin NMI, oscillator fault
  input wire logic timer0_ccr0_flag,     // Timer 0 channel 0
  input wire logic [2:0] timer0_flags,   // Timer 0 ch1, ch2, overflow
  input wire logic timer1_ccr0_flag,     // Timer 1 channel 0
  input wire logic [2:0] timer1_flags,   // Timer 1 ch1, ch2, overflow
  input wire logic counter_clock_flag,   // Real-time counter
  input wire logic watchdog_flag,        // Watchdog interval mode
  input wire logic [3:0] serial_a_flags, // Rx, tx, tx complete, start
  input wire logic [15:0] serial_b_flags,// SPI rx,tx; then 14 two-wire flags
  input wire logic [5:0] converter_flags,// Done, in, below, above, tov, ov
  input wire logic [7:0] port1_flags,    // Port 1 pin changes
  input wire logic [6:0] port2_flags,    // Port 2 pin changes
  // Vector to the core
  output logic vec_pending_r,            // A vector is presented
  output logic vec_nonmaskable_r,        // Presented vector is non-maskable
  output logic [15:0] vec_word_addr_r,   // Vector word address
  output logic [15:0] vec_handler_r,     // Handler start address
  output logic [5:0] vec_priority_r,     // Priority number
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] awaddr,  // Write address
  input wire logic awvalid,              // Write address valid
  output logic awready_r,                // Write address ready
  input wire logic [31:0] wdata,         // Write data
  input wire logic [3:0] wstrb,          // Byte enables
  input wire logic wvalid,               // Write data valid
  output logic wready_r,                 // Write data ready
  output logic [1:0] bresp_r,            // Write response
  output logic bvalid_r,                 // Write response valid
  input wire logic bready,               // Write response ready
  input wire logic [ADDR_W-1:0] araddr,  // Read address
  input wire logic arvalid,              // Read address valid
  output logic arready_r,                // Read address ready
  output logic [31:0] rdata_r,           // Read data
  output logic [1:0] rresp_r,            // Read response
  output logic rvalid_r,                 // Read data valid
  input wire logic rready                // Read data ready
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0] ctrl_r;                             // Control bits
  logic [15:0] handler_r [ivp_pkg::N_SRC];        // Vector words
  logic [15:0] sig_r [ivp_pkg::N_SIG];            // Signature words
  logic [15:0] wr_idx_r;                          // Held write index
  logic [31:0] wr_data_r;                         // Held write data
  logic [3:0] wr_strb_r;                          // Held byte enables
  logic wr_go;                                    // Both halves held
  logic [15:0] rd_idx;                            // Read index
  logic [31:0] rd_data;                           // Read mux result
  logic rd_hit;                                   // Read index mapped
  logic wr_hit;                                   // Write index mapped
  logic [ivp_pkg::N_SRC-1:0] req;                 // Per-source requests
  logic [ivp_pkg::N_SRC-1:0] req_gated;           // After global enable
  logic sel_found;                                // Winner exists
  logic [ivp_pkg::SRC_W-1:0] sel_idx;             // Winner index
  logic [3:0] hidx;                               // Handler slot of write
  logic [3:0] ridx;                               // Handler slot of read
  logic [1:0] sidx;                               // Signature slot of write
  logic [1:0] rsidx;                              // Signature slot of read
  logic [15:0] strb_mask;                         // Lane mask for 16 bits
  // Group outputs
  logic rst_any, sys_any, usr_any, t0_any, t1_any;
  logic sa_any, sb_any, adc_any, p1_any, p2_any;
  logic [ivp_pkg::IV_W-1:0] rst_iv, sys_iv, usr_iv, t0_iv, t1_iv;
  logic [ivp_pkg::IV_W-1:0] sa_iv, sb_iv, adc_iv, p1_iv, p2_iv;
  logic [3:0] sa_en;                              // Serial A mode enables
  logic [15:0] sb_en;                             // Serial B mode enables

  // ----------------------------------------------------------------
  // Source groups
  // ----------------------------------------------------------------
  // Reset causes all land on the top vector
  flag_group #(.N(9), .CW(ivp_pkg::IV_W)) u_rst (
    .flags(reset_flags), .enables('1), .any(rst_any), .code(rst_iv));

  // System non-maskable causes
  flag_group #(.N(5), .CW(ivp_pkg::IV_W)) u_sys (
    .flags(sys_nmi_flags), .enables('1), .any(sys_any), .code(sys_iv));

  // User non-maskable causes
  flag_group #(.N(2), .CW(ivp_pkg::IV_W)) u_usr (
    .flags(user_nmi_flags), .enables('1), .any(usr_any), .code(usr_iv));

  // Timer 0 shared vector
  flag_group #(.N(3), .CW(ivp_pkg::IV_W)) u_t0 (
    .flags(timer0_flags), .enables('1), .any(t0_any), .code(t0_iv));

  // Timer 1 shared vector
  flag_group #(.N(3), .CW(ivp_pkg::IV_W)) u_t1 (
    .flags(timer1_flags), .enables('1), .any(t1_any), .code(t1_iv));

  // Serial A: tx complete and start count only in asynchronous mode
  assign sa_en = {{2{ctrl_r[ivp_pkg::CTRL_SA_ASYNC]}}, 2'b11};
  flag_group #(.N(4), .CW(ivp_pkg::IV_W)) u_sa (
    .flags(serial_a_flags), .enables(sa_en), .any(sa_any), .code(sa_iv));

  // Serial B: SPI pair or the fourteen two-wire flags, by mode
  assign sb_en = {{14{ctrl_r[ivp_pkg::CTRL_SB_TWI]}},
                  {2{~ctrl_r[ivp_pkg::CTRL_SB_TWI]}}};
  flag_group #(.N(16), .CW(ivp_pkg::IV_W)) u_sb (
    .flags(serial_b_flags), .enables(sb_en), .any(sb_any), .code(sb_iv));

  // Converter flags
  flag_group #(.N(6), .CW(ivp_pkg::IV_W)) u_adc (
    .flags(converter_flags), .enables('1), .any(adc_any), .code(adc_iv));

  // Port 1 pin changes
  flag_group #(.N(8), .CW(ivp_pkg::IV_W)) u_p1 (
    .flags(port1_flags), .enables('1), .any(p1_any), .code(p1_iv));

  // Port 2 pin changes
  flag_group #(.N(7), .CW(ivp_pkg::IV_W)) u_p2 (
    .flags(port2_flags), .enables('1), .any(p2_any), .code(p2_iv));

  // ----------------------------------------------------------------
  // Priority selection
  // ----------------------------------------------------------------
  // Requests in source order, highest priority at bit 0
  assign req = {p2_any, p1_any, adc_any, sb_any, sa_any, watchdog_flag,
                counter_clock_flag, t1_any, timer1_ccr0_flag, t0_any,
                timer0_ccr0_flag, usr_any, sys_any, rst_any};

  // Maskable sources drop out while the global enable is clear
  always_comb begin
    req_gated = req;
    if (!ctrl_r[ivp_pkg::CTRL_GIE]) begin
      req_gated[ivp_pkg::N_SRC-1:ivp_pkg::N_NMI] = '0;
    end
  end

  vector_select #(.N(ivp_pkg::N_SRC), .IW(ivp_pkg::SRC_W)) u_sel (
    .req(req_gated), .found(sel_found), .idx(sel_idx));

  // Register the winner and its vector word for the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_pending_r <= 1'b0;
      vec_nonmaskable_r <= 1'b0;
      vec_word_addr_r <= '0;
      vec_handler_r <= '0;
      vec_priority_r <= '0;
    end else begin
      vec_pending_r <= sel_found;
      vec_nonmaskable_r <= sel_found && (sel_idx < ivp_pkg::SRC_W'(ivp_pkg::N_NMI));
      if (sel_found) begin
        vec_word_addr_r <= ivp_pkg::VEC_ADDR[sel_idx];
        vec_handler_r <= handler_r[sel_idx];
        vec_priority_r <= ivp_pkg::VEC_PRIO[sel_idx];
      end else begin
        vec_word_addr_r <= '0;
        vec_handler_r <= '0;
        vec_priority_r <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign wr_go = !awready_r && !wready_r && !bvalid_r;

  // Address and data are taken in either order, then answered together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= ivp_pkg::RESP_OKAY;
      wr_idx_r <= '0;
      wr_data_r <= '0;
      wr_strb_r <= '0;
    end else begin
      if (awvalid && awready_r) begin
        awready_r <= 1'b0;
        wr_idx_r <= awaddr[17:2];
      end
      if (wvalid && wready_r) begin
        wready_r <= 1'b0;
        wr_data_r <= wdata;
        wr_strb_r <= wstrb;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? ivp_pkg::RESP_OKAY : ivp_pkg::RESP_SLVERR;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Write decode: slot numbers and lane mask
  always_comb begin
    hidx = 4'((ivp_pkg::VEC_TOP - wr_idx_r) >> 1);
    sidx = 2'((wr_idx_r - ivp_pkg::SIG_BASE) >> 1);
    strb_mask = {{8{wr_strb_r[1]}}, {8{wr_strb_r[0]}}};
    wr_hit = 1'b0;
    if (wr_idx_r == ivp_pkg::IDX_CTRL) begin
      wr_hit = 1'b1;
    end else if (wr_idx_r >= ivp_pkg::VEC_LOW && !wr_idx_r[0]) begin
      wr_hit = 1'b1;
    end else if (wr_idx_r >= ivp_pkg::SIG_BASE && wr_idx_r <= ivp_pkg::SIG_LAST
                 && !wr_idx_r[0]) begin
      wr_hit = 1'b1;
    end else if (wr_idx_r == ivp_pkg::IDX_STATUS
                 || (wr_idx_r >= ivp_pkg::IDX_RESET_IV
                     && wr_idx_r <= ivp_pkg::IDX_P2_IV && !wr_idx_r[0])) begin
      wr_hit = 1'b1;  // Read-only, write ignored
    end
  end

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= ivp_pkg::CTRL_RST;
    end else if (wr_go && wr_idx_r == ivp_pkg::IDX_CTRL && wr_strb_r[0]) begin
      ctrl_r <= wr_data_r[2:0];
    end
  end

  // Handler words, one per vector location
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < ivp_pkg::N_SRC; i++) begin
        handler_r[i] <= ivp_pkg::HANDLER_RST;
      end
    end else if (wr_go && wr_idx_r >= ivp_pkg::VEC_LOW && !wr_idx_r[0]) begin
      handler_r[hidx] <= (handler_r[hidx] & ~strb_mask)
                         | (wr_data_r[15:0] & strb_mask);
    end
  end

  // Signature words just below the vector region
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < ivp_pkg::N_SIG; i++) begin
        sig_r[i] <= ivp_pkg::SIG_RST;
      end
    end else if (wr_go && wr_idx_r >= ivp_pkg::SIG_BASE
                 && wr_idx_r <= ivp_pkg::SIG_LAST && !wr_idx_r[0]) begin
      sig_r[sidx] <= (sig_r[sidx] & ~strb_mask)
                     | (wr_data_r[15:0] & strb_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign rd_idx = araddr[17:2];

  // Read mux; group vector registers show the lowest enabled pending flag
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    ridx = 4'((ivp_pkg::VEC_TOP - rd_idx) >> 1);
    rsidx = 2'((rd_idx - ivp_pkg::SIG_BASE) >> 1);
    if (rd_idx >= ivp_pkg::VEC_LOW && !rd_idx[0]) begin
      rd_data[15:0] = handler_r[ridx];
    end else if (rd_idx >= ivp_pkg::SIG_BASE && rd_idx <= ivp_pkg::SIG_LAST
                 && !rd_idx[0]) begin
      rd_data[15:0] = sig_r[rsidx];
    end else begin
      unique case (rd_idx)
        ivp_pkg::IDX_CTRL: begin
          rd_data[2:0] = ctrl_r;
        end
        ivp_pkg::IDX_STATUS: begin
          rd_data[ivp_pkg::ST_PRIO_LSB +: 6] = vec_priority_r;
          rd_data[ivp_pkg::ST_PEND] = vec_pending_r;
          rd_data[ivp_pkg::ST_NMI] = vec_nonmaskable_r;
          rd_data[ivp_pkg::ST_ADDR_LSB +: 16] = vec_word_addr_r;
        end
        ivp_pkg::IDX_RESET_IV: begin
          rd_data[ivp_pkg::IV_W-1:0] = rst_iv;
        end
        ivp_pkg::IDX_T0_IV: begin
          rd_data[ivp_pkg::IV_W-1:0] = t0_iv;
        end
        ivp_pkg::IDX_T1_IV: begin
          rd_data[ivp_pkg::IV_W-1:0] = t1_iv;
        end
        ivp_pkg::IDX_SA_IV: begin
          rd_data[ivp_pkg::IV_W-1:0] = sa_iv;
        end
        ivp_pkg::IDX_SB_IV: begin
          rd_data[ivp_pkg::IV_W-1:0] = sb_iv;
        end
        ivp_pkg::IDX_ADC_IV: begin
          rd_data[ivp_pkg::IV_W-1:0] = adc_iv;
        end
        ivp_pkg::IDX_P1_IV: begin
          rd_data[ivp_pkg::IV_W-1:0] = p1_iv;
        end
        ivp_pkg::IDX_P2_IV: begin
          rd_data[ivp_pkg::IV_W-1:0] = p2_iv;
        end
        default: begin
          rd_hit = 1'b0;  // Unmapped index
        end
      endcase
    end
  end

  // One read at a time; data registered with the handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= ivp_pkg::RESP_OKAY;
    end else begin
      if (arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_data;
        rresp_r <= rd_hit ? ivp_pkg::RESP_OKAY : ivp_pkg::RESP_SLVERR;
      end
      if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // Other group codes feed the read mux; system/user NMI codes feed nothing and
  // are kept for symmetry of the group structure.
  logic unused_codes;
  assign unused_codes = ^{sys_iv, usr_iv, araddr[1:0], awaddr[1:0], wr_strb_r[3:2]};

endmodule

// File: ivp_checker.sv
/* Assertions on the vector outputs and bus handshakes.
   Bound to interrupt_vector_priority; sees only its ports. */
`timescale 1ns/1ps
module ivp_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic [8:0] reset_flags, // Reset causes
  input wire logic [4:0] sys_nmi_flags, // System NMI
  input wire logic [1:0] user_nmi_flags, // User NMI
  input wire logic vec_pending_r, // Vector shown
  input wire logic vec_nonmaskable_r, // Non-maskable
  input wire logic [15:0] vec_word_addr_r, // Vector word
  input wire logic [5:0] vec_priority_r, // Priority
  input wire logic awvalid, // Write address valid
  input wire logic awready_r, // Write address ready
  input wire logic wvalid, // Write data valid
  input wire logic wready_r, // Write data ready
  input wire logic bvalid_r, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic arvalid, // Read address valid
  input wire logic arready_r, // Read address ready
  input wire logic rvalid_r // Read data valid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken together, then the answer
  sequence wr_take; awvalid && awready_r && wvalid && wready_r; endsequence
  sequence wr_answer; !awready_r && !wready_r ##1 bvalid_r; endsequence
  chk_reset_vec: assert property (
    |reset_flags |=> vec_word_addr_r == 16'hfffe && vec_priority_r == 6'd63)
    else $error("reset vector wrong");
  chk_sys_nmi: assert property (
    !(|reset_flags) && |sys_nmi_flags |=> vec_word_addr_r == 16'hfffc && vec_nonmaskable_r)
    else $error("system nmi vector wrong");
  chk_user_nmi: assert property (
    !(|reset_flags) && !(|sys_nmi_flags) && |user_nmi_flags
      |=> vec_word_addr_r == 16'hfffa && vec_priority_r == 6'd61)
    else $error("user nmi vector wrong");
  chk_addr_prio: assert property (
    vec_pending_r |-> vec_word_addr_r == 16'hffe4 + {9'h000, vec_priority_r - 6'd50, 1'b0})
    else $error("address and priority disagree");
  chk_nmi_class: assert property (
    vec_pending_r |-> vec_nonmaskable_r == (vec_priority_r > 6'd60))
    else $error("nonmaskable class wrong");
  chk_idle_zero: assert property (
    !vec_pending_r |-> vec_word_addr_r == 16'h0000 && vec_priority_r == 6'h00)
    else $error("idle vector not zero");
  chk_write_walk: assert property (wr_take |=> wr_answer)
    else $error("write walk wrong");
  chk_resp_hold: assert property (bvalid_r && !bready |=> bvalid_r)
    else $error("write response dropped");
  chk_read_walk: assert property (arvalid && arready_r |=> rvalid_r && !arready_r)
    else $error("read walk wrong");
endmodule
bind interrupt_vector_priority ivp_checker i_ivp_checker (.*);

// File: ivp_pkg.sv
/*
  Holds the constants shared by the interrupt vector and priority logic:
  source order, vector word addresses, priorities, register indices and
  reset values.
  Assumes a single 20 MHz clock domain and an AXI4-Lite register bus with
  32-bit data where byte address = 4 x register index.
*/
// What this block does
// - Reset causes vector at FFFEh, priority 63
// - System non-maskable causes vector FFFCh, priority 62
// - Pin NMI, oscillator fault: FFFAh, priority 61
// - Timer0 channel 0 FFF8h; others share FFF6h
// - Timer1 channel 0 FFF4h; others share FFF2h
// - Counter clock FFF0h/56, watchdog interval FFEEh/55
// - Serial A flags merge to FFECh, priority 54
// - Serial B flags merge to FFEAh, priority 53
// - Converter flags merge to FFE8h, priority 52
// - Port 1 pin flags merge to FFE6h/51
// - Port 2 pin flags merge to FFE4h/50
// - Signature words at 0FF80h to 0FF86h
// - Each vector holds a 16-bit handler address
package ivp_pkg;

  // ----------------------------------------------------------------
  // Source order, highest priority first
  // ----------------------------------------------------------------
  localparam int N_SRC = 14;        // Vector sources
  localparam int N_NMI = 3;         // First three sources ignore the enable
  localparam int SRC_W = 4;         // Width of a source index
  localparam int IV_W = 6;          // Width of a group vector code

  // Vector word addresses per source
  localparam logic [15:0] VEC_ADDR [N_SRC] = '{
    16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2,
    16'hfff0, 16'hffee, 16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4};
  // Priority number per source
  localparam logic [5:0] VEC_PRIO [N_SRC] = '{
    6'd63, 6'd62, 6'd61, 6'd60, 6'd59, 6'd58, 6'd57,
    6'd56, 6'd55, 6'd54, 6'd53, 6'd52, 6'd51, 6'd50};
  localparam logic [15:0] VEC_TOP = 16'hfffe;  // Highest vector word
  localparam logic [15:0] VEC_LOW = 16'hffe4;  // Lowest vector word

  // ----------------------------------------------------------------
  // Signature words
  // ----------------------------------------------------------------
  localparam int N_SIG = 4;                    // Two debug, two loader
  localparam logic [15:0] SIG_BASE = 16'hff80; // First signature word
  localparam logic [15:0] SIG_LAST = 16'hff86; // Last signature word

  // ----------------------------------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_CTRL = 16'h0100;     // Control
  localparam logic [15:0] IDX_STATUS = 16'h0102;   // Selected vector
  localparam logic [15:0] IDX_RESET_IV = 16'h0110; // reset_cause_vector
  localparam logic [15:0] IDX_T0_IV = 16'h0112;    // timer0_vector_reg
  localparam logic [15:0] IDX_T1_IV = 16'h0114;    // timer1_vector_reg
  localparam logic [15:0] IDX_SA_IV = 16'h0116;    // serial_a_vector_reg
  localparam logic [15:0] IDX_SB_IV = 16'h0118;    // serial_b_vector_reg
  localparam logic [15:0] IDX_ADC_IV = 16'h011a;   // converter_vector_reg
  localparam logic [15:0] IDX_P1_IV = 16'h011c;    // port1_vector_reg
  localparam logic [15:0] IDX_P2_IV = 16'h011e;    // port2_vector_reg

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_GIE = 0;       // Global maskable enable
  localparam int CTRL_SA_ASYNC = 1;  // Serial A in asynchronous mode
  localparam int CTRL_SB_TWI = 2;    // Serial B in two-wire mode
  localparam int ST_PRIO_LSB = 0;    // Status: priority field
  localparam int ST_PEND = 8;        // Status: a vector is presented
  localparam int ST_NMI = 9;         // Status: it is non-maskable
  localparam int ST_ADDR_LSB = 16;   // Status: vector word address
  localparam logic [2:0] CTRL_RST = 3'h0;        // Control after reset
  localparam logic [15:0] HANDLER_RST = 16'h0000; // Handler words after reset
  localparam logic [15:0] SIG_RST = 16'hffff;     // Signatures after reset

  localparam logic [1:0] RESP_OKAY = 2'h0;   // AXI OKAY
  localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI SLVERR

endpackage

// File: test_interrupt_vector_priority.sv
/* Self-checking bench for interrupt_vector_priority with a core model.
   Assumes the bus timing of the design. */
`timescale 1ns/1ps
module test_interrupt_vector_priority;
  logic aclk = 1'b0, aresetn = 1'b0, fetch_r, vec_pending_r, vec_nonmaskable_r;
  logic [15:0] vec_word_addr_r, vec_handler_r, jump_addr_r;
  logic [5:0] vec_priority_r, converter_flags;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r, user_nmi_flags;
  logic [31:0] rdata_r, wdata = '0, r;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [3:0] wstrb = 4'hf, serial_a_flags;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [8:0] reset_flags;
  logic [4:0] sys_nmi_flags;
  logic timer0_ccr0_flag, timer1_ccr0_flag, counter_clock_flag, watchdog_flag;
  logic [2:0] timer0_flags, timer1_flags;
  logic [15:0] serial_b_flags, h [14];
  logic [7:0] port1_flags;
  logic [6:0] port2_flags;
  logic [33:0] exp_q [$];
  int seed = 16, fails = 0, cmp_count = 0;
  interrupt_vector_priority i_interrupt_vector_priority (.*);
  vector_fetch_model i_vector_fetch_model (.*);
  initial forever #25 aclk = ~aclk;
  task end_sim;
    if (exp_q.size() != 0) fails++;
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [33:0] seen);
    logic [33:0] e;
    e = exp_q.pop_front();
    cmp_count++;
    if (seen !== e) begin
      fails++;
      $display("Error result expected %h seen %h", e, seen);
    end
  endtask
  // Monitor: each answer takes the oldest note
  always @(posedge aclk) begin
    if (bvalid_r === 1'b1 && bready) chk({bresp_r, 32'h0});
    if (rvalid_r === 1'b1 && rready) chk({rresp_r, rdata_r});
    if (fetch_r === 1'b1) chk({18'h0, jump_addr_r});
  end
  task wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] rs);
    exp_q.push_back({rs, 32'h0});
    awaddr <= {idx, 2'h0}; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready_r) awvalid <= 1'b0;
      if (wready_r) wvalid <= 1'b0;
    end while (!(bvalid_r && bready));
  endtask
  task rd(input logic [15:0] idx, input logic [33:0] e);
    exp_q.push_back(e);
    araddr <= {idx, 2'h0}; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready_r) arvalid <= 1'b0;
    end while (!rvalid_r);
  endtask
  task clr;
    {reset_flags, sys_nmi_flags, user_nmi_flags, timer0_ccr0_flag, timer0_flags} <= '0;
    {timer1_ccr0_flag, timer1_flags, counter_clock_flag, watchdog_flag} <= '0;
    {serial_a_flags, serial_b_flags, converter_flags, port1_flags, port2_flags} <= '0;
  endtask
  // Raise one source flag: below 14 a random bit of its group (serial A and B: one of the first two), else a fixed bit
  task put(input int s);
    r = $random(seed);
    case (s)
      0: reset_flags <= 9'h001 << (r % 9);
      1: sys_nmi_flags <= 5'h01 << (r % 5);
      2: user_nmi_flags <= 2'h1 << r[0];
      3: timer0_ccr0_flag <= 1'b1;
      4: timer0_flags <= 3'h1 << (r % 3);
      5: timer1_ccr0_flag <= 1'b1;
      6: timer1_flags <= 3'h1 << (r % 3);
      7: counter_clock_flag <= 1'b1;
      8: watchdog_flag <= 1'b1;
      9: serial_a_flags <= 4'h1 << r[0];
      10: serial_b_flags <= 16'h0001 << r[0];
      11: converter_flags <= 6'h01 << (r % 6);
      12: port1_flags <= 8'h01 << r[2:0];
      13: port2_flags <= 7'h01 << (r % 7);
      14: serial_a_flags <= 4'h8;
      15: serial_b_flags <= 16'h0020;
      default: port1_flags <= 8'h10;
    endcase
  endtask
  function automatic logic [33:0] st(input int s);
    return {2'h0, 16'hfffe - 16'(2 * s), 6'h00, s < 3, 1'b1, 2'h0, 6'(63 - s)};
  endfunction
  // Source s with port 2 also pending; fh is the handler fetched, -1 none
  task step(input int s, input int fh, input logic [33:0] e);
    clr;
    repeat (2) @(posedge aclk);
    if (fh >= 0) exp_q.push_back({18'h0, h[fh]});
    put(s);
    if (s != 13) put(13);
    repeat (3) @(posedge aclk);
    rd(16'h0102, e);
  endtask
  initial begin
    clr;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(16'h0100, 34'h0);
    rd(16'hfffe, 34'h0);
    rd(16'hff80, 34'h0ffff);
    rd(16'hff86, 34'h0ffff);
    wr(16'hffe0, 32'h1234, 2'h2);
    for (int s = 0; s < 14; s++) begin
      h[s] = 16'($random(seed));
      wr(16'hfffe - 16'(2 * s), {16'h0, h[s]}, 2'h0);
    end
    wr(16'h0100, 32'h1, 2'h0);
    for (int s = 0; s < 14; s++) begin
      step(s, s, st(s));
      rd(16'hfffe - 16'(2 * s), {18'h0, h[s]});
    end
    step(14, 13, st(13));
    step(15, 13, st(13));
    step(16, 12, st(12));
    rd(16'h011c, 34'h0a);
    wr(16'h0100, 32'h3, 2'h0);
    step(14, 9, st(9));
    wr(16'h0100, 32'h5, 2'h0);
    step(15, 10, st(10));
    wr(16'h0100, 32'h0, 2'h0);
    step(3, -1, 34'h0);
    step(2, 2, st(2));
    @(posedge aclk);
    end_sim;
  end
  initial begin
    #250000;
    fails++;
    end_sim;
  end
endmodule

// File: vector_fetch_model.sv
/* Core side model: loads the handler word when a vector appears.
   Assumes the vector outputs are stable one edge after change. */
`timescale 1ns/1ps
module vector_fetch_model (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic vec_pending_r, // Vector shown
  input wire logic [15:0] vec_handler_r, // Handler word
  output logic fetch_r, // One-cycle fetch strobe
  output logic [15:0] jump_addr_r // Loaded handler word
);
  logic seen_r; // Pending seen last edge
  // Fetch once each time vec_pending_r rises after none was shown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_r <= 1'b0;
      fetch_r <= 1'b0;
    end else begin
      seen_r <= vec_pending_r;
      fetch_r <= vec_pending_r && !seen_r;
      if (vec_pending_r && !seen_r) jump_addr_r <= vec_handler_r;
    end
  end
endmodule

// File: vector_select.sv
/*
  Picks the highest-priority pending source; index 0 is the highest.
  Assumes requests are already masked by the caller.
*/
`timescale 1ns/1ps
module vector_select #(
  parameter int N = 14,     // Sources
  parameter int IW = 4      // Index width
) (
  input wire logic [N-1:0] req, // Pending requests
  output logic found,           // Some request pending
  output logic [IW-1:0] idx     // Winning source
);

  // ----------------------------------------------------------------
  // Scan from lowest priority up so the highest one overrides
  // ----------------------------------------------------------------
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = IW'(i);
      end
    end
  end

endmodule
